// ### src/bpsc_pkg.sv
// constants and types for the backup power switchover controller
package bpsc_pkg;
    // clock and timing
    localparam int  CLK_HZ              = 25000000;
    localparam int  MIRROR_RELOAD_MS    = 66;
    localparam int  DEBOUNCE_SHORT_MS   = 1;
    localparam int  DEBOUNCE_LONG_MS    = 1000;
    localparam int  ARM_DIRECT_MS       = 2;
    localparam int  ARM_LEVEL_MS        = 10;
    localparam int  CYC_PER_MS          = CLK_HZ / 1000;
    localparam int  MIRROR_RELOAD_CYC   = MIRROR_RELOAD_MS * CYC_PER_MS;
    localparam int  DEBOUNCE_SHORT_CYC  = DEBOUNCE_SHORT_MS * CYC_PER_MS;
    localparam int  DEBOUNCE_LONG_CYC   = DEBOUNCE_LONG_MS * CYC_PER_MS;
    localparam int  ARM_DIRECT_CYC      = ARM_DIRECT_MS * CYC_PER_MS;
    localparam int  ARM_LEVEL_CYC       = ARM_LEVEL_MS * CYC_PER_MS;
    localparam int  CNT_W               = 32;

    // avalon register map, byte addresses
    localparam logic [3:0] ADDR_PMU     = 4'h0;
    localparam logic [3:0] ADDR_CTRL    = 4'h4;
    localparam logic [3:0] ADDR_STATUS  = 4'h8;
    localparam logic [3:0] ADDR_NVPMU   = 4'hc;

    // pmu byte fields: [7:6] resv, [5:4] mode, [3:2] resistor, [1:0] charger mode
    localparam int  MODE_LSB  = 4;
    localparam int  RES_LSB   = 2;
    localparam int  TCM_LSB   = 0;
    localparam logic [7:0] PMU_RESET = 8'h00;

    // ctrl fields
    localparam int  CTRL_POWER_ON_IRQ_ENABLE = 0;
    localparam int  CTRL_BACKUP_IRQ_ENABLE  = 1;
    localparam int  CTRL_POWER_ON_FLAG  = 0;
    localparam int  CTRL_BSF   = 1;
    localparam int  CTRL_CLKIM = 8;

    // status fields
    localparam int  ST_POWER_ON_FLAG    = 0;
    localparam int  ST_BSF     = 1;
    localparam int  ST_BACKUP  = 2;
    localparam int  ST_BUSY    = 3;
    localparam int  ST_BUSOK   = 4;
    localparam int  ST_CHGEN   = 5;
    localparam int  ST_CLKWAKE = 6;

    localparam logic [1:0] MODE_OFF0   = 2'h0;
    localparam logic [1:0] MODE_DIRECT = 2'h1;
    localparam logic [1:0] MODE_LEVEL  = 2'h2;
    localparam logic [1:0] TCM_OFF     = 2'h0;

    typedef enum logic [2:0] {
        BPSC_RELOAD, BPSC_MAIN, BPSC_BACKUP, BPSC_DEBOUNCE, BPSC_STANDBY
    } bpsc_state_t;
endpackage

// ### src/bpsc_backup_power_switchover_ctrl.sv
// backup power switchover controller top level
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
// Function
// RULE1: reset clears volatile state, mirror to defaults
// RULE2: reload mirror from nonvolatile copy after power-up
// RULE3: power-on flag set on reset, cleared by 0
// RULE4: power-on interrupt when its enable is set
// RULE5: flag cleared on collapse, set on recovery
// RULE6: debounce 1 ms or 1000 ms before bus
// RULE7: mode 00/11 off, 01 direct, 10 level
// RULE8: direct mode backup while main below backup
// RULE9: level mode uses threshold, else direct behaviour
// RULE10: backup switch flag set on each switchover
// RULE11: backup interrupt held until flag cleared on main
// RULE12: bus released and reset on entering backup
// RULE13: external event input disabled on backup
// RULE14: clock output held low on backup
// RULE15: temperature, interrupt, timestamps keep running on backup
// RULE16: masked backup interrupts wake clock output later; code only sets the status wake bit, clock output on main follows clkOutSrc
// RULE17: disabled mode stays main, flag stays zero
// RULE18: first power from backup means switchover disabled
// RULE19: arm delay 2 ms direct, 10 ms level
// RULE20: charger from mode and resistor fields, defaults off
// RULE21: boosted charger levels only level mode, main high
// RULE22: charger off for mode 00, switch off, backup
// RULE23: comparator inputs synchronised before use
module bpsc_backup_power_switchover_ctrl #(
    parameter int RELOAD_CYC = bpsc_pkg::MIRROR_RELOAD_CYC,
    parameter int DEB_SHORT  = bpsc_pkg::DEBOUNCE_SHORT_CYC,
    parameter int DEB_LONG   = bpsc_pkg::DEBOUNCE_LONG_CYC,
    parameter int ARM_DIRECT = bpsc_pkg::ARM_DIRECT_CYC,
    parameter int ARM_LEVEL  = bpsc_pkg::ARM_LEVEL_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // avalon-mm slave
    input  wire logic [3:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWriteData,
    input  wire logic [3:0]  avsByteEnable,
    output logic [31:0]      avsReadData,
    output logic             avsWaitRequest,
    // supply comparators, asynchronous
    input  wire logic        mainAboveBackup,
    input  wire logic        mainAboveLevel,
    input  wire logic        backupAboveLevel,
    input  wire logic        mainCollapse,
    input  wire logic        voltageLowFlag,
    input  wire logic        mainPresentAtPor,
    // nonvolatile pmu byte and clock interrupt sources
    input  wire logic [7:0]  nvPmuByte,
    input  wire logic        clkIrqEvent,
    input  wire logic        extEventPin,
    input  wire logic        clkOutSrc,
    // power and gating outputs
    output logic             onBackup,
    output logic             serialBusEnable,
    output logic             serialProtoReset,
    output logic             extEventEnable,
    output logic             extEventOut,
    output logic             clockOutPin,
    output logic             tempSenseEnable,
    output logic             chargerEnable,
    output logic [1:0]       chargerModeOut,
    output logic [1:0]       chargerResistorOut,
    output logic             irqOutN
);
    import bpsc_pkg::*;

    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [4:0] syncA_reg;
    logic [4:0] syncB_reg;
    logic [4:0] asyncIn;
    assign asyncIn = {mainPresentAtPor, voltageLowFlag, mainCollapse, backupAboveLevel, mainAboveLevel};
    logic mabA_reg, mabB_reg, evA_reg, evB_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncA_reg <= 5'h00;
            syncB_reg <= 5'h00;
            mabA_reg  <= 1'b1;
            mabB_reg  <= 1'b1;
            evA_reg   <= 1'b0;
            evB_reg   <= 1'b0;
        end else begin
            syncA_reg <= asyncIn;
            syncB_reg <= syncA_reg;  // RULE23
            mabA_reg  <= mainAboveBackup;
            mabB_reg  <= mabA_reg;  // RULE23
            evA_reg   <= extEventPin;
            evB_reg   <= evA_reg;
        end
    end

    wire mainHighLvl = syncB_reg[0];
    wire backHighLvl = syncB_reg[1];
    wire collapse    = syncB_reg[2];
    wire vlfSync     = syncB_reg[3];
    wire mainAtPor   = syncB_reg[4];
    wire mainHighBak = mabB_reg;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0]  pmu_reg;
    logic [7:0]  clkMask_reg;
    logic        power_on_irq_enable_reg;
    logic        backup_irq_enable_reg;
    logic        porFlag_reg;
    logic        bsFlag_reg;
    logic        clkWake_reg;
    logic        strapDone_reg;
    logic        noSwitch_reg;
    logic [1:0]  modePrev_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] arm_reg;
    bpsc_state_t state_reg;
    bpsc_state_t state_next;
    logic        collapsePrev_reg;

    wire [1:0] modeSel  = pmu_reg[MODE_LSB +: 2];
    wire [1:0] tcmSel   = pmu_reg[TCM_LSB +: 2];
    wire [1:0] resSel   = pmu_reg[RES_LSB +: 2];
    // mode 00 and 11 both disable switchover; strap overrides
    wire directMode = (modeSel == MODE_DIRECT);  // RULE7
    wire levelMode  = (modeSel == MODE_LEVEL);  // RULE7
    wire switchOn   = (directMode || levelMode) && !noSwitch_reg;  // RULE17 RULE18
    wire armed      = (arm_reg == '0);

    // direct: compare main to backup; level: threshold, else fall back to direct
    wire goBackDirect = !mainHighBak;  // RULE8
    wire goBackLevel  = mainHighLvl ? 1'b0 : (backHighLvl ? 1'b1 : !mainHighBak);  // RULE9
    wire wantBackup   = switchOn && armed && (levelMode ? goBackLevel : goBackDirect);

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire selPmu    = (avsAddress == ADDR_PMU);
    wire selCtrl   = (avsAddress == ADDR_CTRL);
    wire selStatus = (avsAddress == ADDR_STATUS);
    wire selNv     = (avsAddress == ADDR_NVPMU);
    wire busyReload = (state_reg == BPSC_RELOAD);
    // stall during reload; a read takes one wait state so its registered data stands
    logic rdValid_reg;
    wire rdStall = avsRead && !rdValid_reg;
    assign avsWaitRequest = ((avsRead || avsWrite) && busyReload) || rdStall;
    wire wrOk     = avsWrite && !avsWaitRequest;
    wire wrPmu    = wrOk && selPmu && avsByteEnable[0];
    wire wrCtrl0  = wrOk && selCtrl && avsByteEnable[0];
    wire wrCtrl1  = wrOk && selCtrl && avsByteEnable[1];
    wire porClr   = wrCtrl0 && !avsWriteData[CTRL_POWER_ON_FLAG];  // RULE3
    // backup flag may only be cleared back on main supply
    wire bsClr    = wrCtrl0 && !avsWriteData[CTRL_BSF] && (state_reg == BPSC_MAIN);  // RULE11

    wire [31:0] statusWord = {25'h0, clkWake_reg, chargerEnable, serialBusEnable, busyReload,
                              onBackup, bsFlag_reg, porFlag_reg};
    wire [31:0] ctrlWord   = {16'h0, clkMask_reg, 6'h0, backup_irq_enable_reg, power_on_irq_enable_reg};
    wire [31:0] rdMux = selPmu ? {24'h0, pmu_reg} :
                        selCtrl ? ctrlWord :
                        selStatus ? statusWord :
                        selNv ? {24'h0, nvPmuByte} : 32'h0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avsReadData <= 32'h0;
            rdValid_reg <= 1'b0;
        end else begin
            if (avsRead) avsReadData <= rdMux;
            rdValid_reg <= avsRead && !busyReload && !rdValid_reg;
        end
    end

    // ----------------------------------------
    // power state machine
    // ----------------------------------------
    wire [CNT_W-1:0] debTarget = vlfSync ? CNT_W'(DEB_LONG) : CNT_W'(DEB_SHORT);  // RULE6
    wire reloadDone = (cnt_reg >= CNT_W'(RELOAD_CYC - 1));  // RULE2
    wire debDone    = (cnt_reg >= debTarget - CNT_W'(1));
    wire wantBackupRaw = levelMode ? goBackLevel : goBackDirect;
    wire mainOk     = !wantBackupRaw;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            BPSC_RELOAD:   if (reloadDone) state_next = BPSC_MAIN;
            BPSC_MAIN:     if (wantBackup) state_next = BPSC_BACKUP;
            BPSC_BACKUP:   if (mainOk) state_next = BPSC_DEBOUNCE;
            BPSC_DEBOUNCE: if (!mainOk) state_next = BPSC_BACKUP;
                           else if (debDone) state_next = BPSC_MAIN;  // RULE6
            BPSC_STANDBY:  state_next = BPSC_STANDBY;
        endcase
    end

    wire inState = (state_reg == BPSC_RELOAD) || (state_reg == BPSC_DEBOUNCE);
    wire enterBackup = (state_reg == BPSC_MAIN) && (state_next == BPSC_BACKUP);
    wire modeArmEvt  = (modeSel != modePrev_reg) && (directMode || levelMode);
    wire [CNT_W-1:0] armLoad = levelMode ? CNT_W'(ARM_LEVEL) : CNT_W'(ARM_DIRECT);  // RULE19

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= BPSC_RELOAD;  // RULE1
            cnt_reg   <= '0;
            arm_reg   <= '0;
            modePrev_reg <= MODE_OFF0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= (inState && state_next == state_reg) ? cnt_reg + CNT_W'(1) : '0;
            modePrev_reg <= modeSel;
            if (modeArmEvt) arm_reg <= armLoad;  // RULE19
            else if (!armed) arm_reg <= arm_reg - CNT_W'(1);
        end
    end

    // ----------------------------------------
    // configuration and flags
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pmu_reg       <= PMU_RESET;  // RULE1 RULE20
            clkMask_reg   <= 8'h00;
            power_on_irq_enable_reg     <= 1'b0;
            backup_irq_enable_reg      <= 1'b0;
            strapDone_reg <= 1'b0;
            noSwitch_reg  <= 1'b0;
        end else begin
            // strap read as reload ends; right after release its synchroniser still holds 0
            if (!strapDone_reg && busyReload && reloadDone) begin
                strapDone_reg <= 1'b1;
                noSwitch_reg  <= !mainAtPor;  // RULE18
            end
            if (busyReload && reloadDone) pmu_reg <= nvPmuByte;  // RULE2
            else if (wrPmu) pmu_reg <= avsWriteData[7:0];
            if (wrCtrl0) begin
                power_on_irq_enable_reg <= avsWriteData[CTRL_POWER_ON_IRQ_ENABLE];
                backup_irq_enable_reg  <= avsWriteData[CTRL_BACKUP_IRQ_ENABLE];
            end
            if (wrCtrl1) clkMask_reg <= avsWriteData[CTRL_CLKIM +: 8];
        end
    end

    // set wins over clear on every flag
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            porFlag_reg      <= 1'b1;  // RULE3
            bsFlag_reg       <= 1'b0;
            clkWake_reg      <= 1'b0;
            collapsePrev_reg <= 1'b0;
        end else begin
            collapsePrev_reg <= collapse;
            if (collapse) porFlag_reg <= 1'b0;  // RULE5
            else if (collapsePrev_reg) porFlag_reg <= 1'b1;  // RULE5
            else if (porClr) porFlag_reg <= 1'b0;
            if (!switchOn && !onBackup) bsFlag_reg <= 1'b0;  // RULE17
            else if (enterBackup) bsFlag_reg <= 1'b1;  // RULE10
            else if (bsClr) bsFlag_reg <= 1'b0;
            if (onBackup && clkIrqEvent && (clkMask_reg != 8'h00)) clkWake_reg <= 1'b1;  // RULE16
            else if (wrCtrl0 && !avsWriteData[CTRL_BSF] && state_reg == BPSC_MAIN) clkWake_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign onBackup         = (state_reg == BPSC_BACKUP) || (state_reg == BPSC_DEBOUNCE);
    assign serialBusEnable  = (state_reg == BPSC_MAIN);  // RULE12 RULE6
    assign serialProtoReset = !serialBusEnable;  // RULE12
    assign extEventEnable   = !onBackup;  // RULE13
    assign extEventOut      = evB_reg && !onBackup;  // RULE13
    assign clockOutPin      = onBackup ? 1'b0 : (clkOutSrc || (clkWake_reg && clkOutSrc));  // RULE14
    assign tempSenseEnable  = 1'b1;  // RULE15
    // boosted levels (codes above direct) need level mode and main above threshold
    wire boostOk = levelMode && mainHighLvl;  // RULE21
    assign chargerEnable = (tcmSel != TCM_OFF) && switchOn && !onBackup
                           && (tcmSel == 2'h1 || boostOk);  // RULE22 RULE21
    assign chargerModeOut     = chargerEnable ? tcmSel : TCM_OFF;  // RULE20
    assign chargerResistorOut = resSel;  // RULE20
    // interrupt path stays live on backup
    assign irqOutN = !((power_on_irq_enable_reg && porFlag_reg) || (backup_irq_enable_reg && bsFlag_reg));  // RULE4 RULE11 RULE15

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence enterSeq;
        enterBackup;
    endsequence
    property backupGatesP;
        @(posedge clk) disable iff (!rstn) enterSeq |=> (!serialBusEnable && clockOutPin == 1'b0 && !extEventEnable);
    endproperty

    backup_gates_a: assert property (backupGatesP) else $error("gating missing on backup");  // RULE12
    clock_out_pin_low_a: assert property (@(posedge clk) disable iff (!rstn) onBackup |-> !clockOutPin)
        else $error("clock output not low");  // RULE14
    bsf_set_a: assert property (@(posedge clk) disable iff (!rstn) enterBackup |=> bsFlag_reg)
        else $error("backup flag not set");  // RULE10
    bsf_off_a: assert property (@(posedge clk) disable iff (!rstn) (!switchOn && !onBackup) |=> !bsFlag_reg)
        else $error("flag set while disabled");  // RULE17
    bs_irq_a: assert property (@(posedge clk) disable iff (!rstn) (backup_irq_enable_reg && bsFlag_reg) |-> !irqOutN)
        else $error("backup irq missing");  // RULE11
    por_irq_a: assert property (@(posedge clk) disable iff (!rstn) (power_on_irq_enable_reg && porFlag_reg) |-> !irqOutN)
        else $error("power-on irq missing");  // RULE4
    por_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (porFlag_reg && !porClr && !collapse) |=> porFlag_reg) else $error("power-on flag lost");  // RULE3
    chg_off_a: assert property (@(posedge clk) disable iff (!rstn)
        (onBackup || tcmSel == TCM_OFF || !switchOn) |-> !chargerEnable) else $error("charger on");  // RULE22
    boost_a: assert property (@(posedge clk) disable iff (!rstn)
        (chargerEnable && tcmSel != 2'h1) |-> boostOk) else $error("boost without level");  // RULE21
    ext_off_a: assert property (@(posedge clk) disable iff (!rstn) onBackup |-> !extEventOut)
        else $error("event passed on backup");  // RULE13
endmodule // bpsc_backup_power_switchover_ctrl

// ### verif/bpsc_supply_model.sv
// supply comparator model standing in for the analogue supply monitor
`timescale 1ns/1ns
module bpsc_supply_model #(
    parameter int LEVEL_MV = 2000,
    parameter int POR_MV   = 950
) (
    // supply levels in millivolts
    input  wire logic [15:0] mainMv,
    input  wire logic [15:0] backupMv,
    // comparator results
    output logic             mainAboveBackup,
    output logic             mainAboveLevel,
    output logic             backupAboveLevel,
    output logic             mainCollapse
);
    // ideal comparators: no hysteresis, so the bench sets clear margins
    assign mainAboveBackup  = mainMv > backupMv;
    assign mainAboveLevel   = mainMv > LEVEL_MV[15:0];
    assign backupAboveLevel = backupMv > LEVEL_MV[15:0];
    assign mainCollapse     = mainMv < POR_MV[15:0];
endmodule // bpsc_supply_model

// ### verif/bpsc_backup_power_switchover_ctrl_tb.sv
// self-checking bench for the backup power switchover controller
`timescale 1ns/1ns
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin nMismatch++; \
    $display("mismatch at %0t got %0h exp %0h", $time, (g), (e)); end end
module bpsc_backup_power_switchover_ctrl_tb;
    import bpsc_pkg::*;
    // ------------------------------------------------------------
    // fixture
    // ------------------------------------------------------------
    localparam int RLD = 20, DS = 5, DL = 50, AD = 8, AL = 16;
    logic        clk, rstn, avsRead, avsWrite, avsWaitRequest;
    logic [3:0]  avsAddress, avsByteEnable;
    logic [31:0] avsWriteData, avsReadData;
    logic        mainAboveBackup, mainAboveLevel, backupAboveLevel, mainCollapse;
    logic        voltageLowFlag, mainPresentAtPor, clkIrqEvent, extEventPin, clkOutSrc;
    logic [7:0]  nvPmuByte;
    logic [15:0] mainMv, backupMv;
    logic        onBackup, serialBusEnable, serialProtoReset, extEventEnable, extEventOut;
    logic        clockOutPin, tempSenseEnable, chargerEnable, irqOutN;
    logic [1:0]  chargerModeOut, chargerResistorOut;
    int          nMismatch = 0;
    int          nChecks = 0;

    bpsc_supply_model bpsc_supply_model_inst (.mainMv, .backupMv, .mainAboveBackup,
        .mainAboveLevel, .backupAboveLevel, .mainCollapse);
    bpsc_backup_power_switchover_ctrl #(.RELOAD_CYC(RLD), .DEB_SHORT(DS), .DEB_LONG(DL),
        .ARM_DIRECT(AD), .ARM_LEVEL(AL)) bpsc_backup_power_switchover_ctrl_inst (
        .clk, .rstn, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
        .avsReadData, .avsWaitRequest, .mainAboveBackup, .mainAboveLevel, .backupAboveLevel,
        .mainCollapse, .voltageLowFlag, .mainPresentAtPor, .nvPmuByte, .clkIrqEvent,
        .extEventPin, .clkOutSrc, .onBackup, .serialBusEnable, .serialProtoReset,
        .extEventEnable, .extEventOut, .clockOutPin, .tempSenseEnable, .chargerEnable,
        .chargerModeOut, .chargerResistorOut, .irqOutN);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // request holds until waitrequest is sampled low at a rising edge; data taken there
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q, output int waits);
        waits = 0;
        @(posedge clk);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= w;
        avsRead <= !w;
        forever begin
            @(posedge clk);
            if (avsWaitRequest === 1'b0) break;
            waits++;
        end
        q = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(negedge clk);
    endtask

    task automatic sup(input int m, input int b);
        @(posedge clk);
        mainMv <= m[15:0];
        backupMv <= b[15:0];
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic tBoot();
        logic [31:0] q;
        int w;
        cyc(1);
        `CHK(serialBusEnable, 1'b0)
        `CHK(irqOutN, 1'b1)
        bus(1'b0, ADDR_STATUS, 32'h0, q, w);
        `CHK(w >= RLD - 3, 1'b1)
        `CHK(q[ST_POWER_ON_FLAG], 1'b1)
        `CHK(q[ST_BUSY], 1'b0)
        bus(1'b0, ADDR_PMU, 32'h0, q, w);
        `CHK(q[7:0], 8'h0e)
        `CHK(chargerResistorOut, 2'h3)
        `CHK(chargerEnable, 1'b0)
        bus(1'b1, ADDR_NVPMU, 32'hff, q, w);
        bus(1'b0, ADDR_NVPMU, 32'h0, q, w);
        `CHK(q[7:0], 8'h0e)
        bus(1'b0, 4'h3, 32'h0, q, w);
        `CHK(q, 32'h0)
    endtask

    task automatic tPor();
        logic [31:0] q;
        int w;
        bus(1'b1, ADDR_CTRL, 32'h0, q, w);
        bus(1'b1, ADDR_CTRL, 32'h1, q, w);
        bus(1'b0, ADDR_STATUS, 32'h0, q, w);
        `CHK(q[ST_POWER_ON_FLAG], 1'b0)
        `CHK(irqOutN, 1'b1)
        sup(500, 0);
        cyc(6);
        sup(3300, 0);
        cyc(6);
        `CHK(irqOutN, 1'b0)
        bus(1'b0, ADDR_STATUS, 32'h0, q, w);
        `CHK(q[ST_POWER_ON_FLAG], 1'b1)
        bus(1'b1, ADDR_CTRL, 32'h0, q, w);
        `CHK(irqOutN, 1'b1)
    endtask

    task automatic tModes();
        logic [31:0] q;
        int w;
        logic b;
        for (int m = 0; m < 4; m++) begin
            b = (m == 1 || m == 2);
            bus(1'b1, ADDR_PMU, {26'h0, m[1:0], 4'h1}, q, w);
            bus(1'b1, ADDR_CTRL, 32'hff02, q, w);
            cyc(AL + 6);
            `CHK(chargerEnable, b)
            `CHK(chargerModeOut, b ? 2'h1 : 2'h0)
            sup(1500, 3000);
            cyc(4);
            @(posedge clk) clkIrqEvent <= 1'b1;
            extEventPin <= 1'b1;
            @(posedge clk) clkIrqEvent <= 1'b0;
            cyc(6);
            `CHK(onBackup, b)
            `CHK(serialProtoReset, b)
            `CHK(extEventEnable, !b)
            `CHK(extEventOut, !b)
            `CHK(clockOutPin, !b)
            `CHK(tempSenseEnable, 1'b1)
            `CHK(irqOutN, !b)
            `CHK(chargerEnable, 1'b0)
            sup(3300, 3000);
            extEventPin <= 1'b0;
            cyc(DS + 8);
            `CHK(serialBusEnable, 1'b1)
            `CHK(irqOutN, !b)
            bus(1'b0, ADDR_STATUS, 32'h0, q, w);
            `CHK(q[ST_BSF], b)
            if (b) `CHK(q[ST_CLKWAKE], 1'b1)
            bus(1'b1, ADDR_CTRL, 32'h0, q, w);
            `CHK(irqOutN, 1'b1)
        end
    endtask

    task automatic tLevel();
        logic [31:0] q;
        int w;
        bus(1'b1, ADDR_PMU, 32'h22, q, w);
        sup(2500, 3000);
        cyc(AL + 6);
        `CHK(onBackup, 1'b0)
        `CHK(chargerEnable, 1'b1)
        `CHK(chargerModeOut, 2'h2)
        @(posedge clk);
        voltageLowFlag <= 1'b1;
        sup(1800, 1900);
        cyc(8);
        `CHK(onBackup, 1'b1)
        sup(3300, 3000);
        cyc(DS + 8);
        `CHK(serialBusEnable, 1'b0)
        cyc(DL);
        `CHK(serialBusEnable, 1'b1)
        @(posedge clk);
        voltageLowFlag <= 1'b0;
        bus(1'b1, ADDR_PMU, 32'h12, q, w);
        cyc(AD + 6);
        `CHK(chargerEnable, 1'b0)
    endtask

    // a start with no main supply leaves switchover off for good
    task automatic tStrap();
        logic [31:0] q;
        int w;
        bus(1'b1, ADDR_CTRL, 32'hff03, q, w);
        @(posedge clk);
        nvPmuByte <= 8'h11;
        mainPresentAtPor <= 1'b0;
        rstn <= 1'b0;
        cyc(5);
        @(posedge clk) rstn <= 1'b1;
        bus(1'b0, ADDR_CTRL, 32'h0, q, w);
        `CHK(q[15:0], 16'h0)
        sup(1500, 3000);
        cyc(AD + 8);
        `CHK(onBackup, 1'b0)
        `CHK(chargerEnable, 1'b0)
    endtask

    // ------------------------------------------------------------
    // run
    // ------------------------------------------------------------
    task automatic printVerdict();
        if (nMismatch == 0 && nChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsAddress = 4'h0;
        avsWriteData = 32'h0;
        avsByteEnable = 4'hf;
        nvPmuByte = 8'h0e;
        mainMv = 16'd3300;
        backupMv = 16'd0;
        voltageLowFlag = 1'b0;
        mainPresentAtPor = 1'b1;
        clkIrqEvent = 1'b0;
        extEventPin = 1'b0;
        clkOutSrc = 1'b1;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        tBoot();
        tPor();
        tModes();
        tLevel();
        tStrap();
        printVerdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        nMismatch++;
        printVerdict();
    end
endmodule // bpsc_backup_power_switchover_ctrl_tb
